/* shared/ssq_pkg.sv */
// sequential break sequencer: register map, field layout, modes, actions
// assumes a 32-bit axi4-lite register bus and twelve numbered match channels
package ssq_pkg;
    localparam int NCH = 12;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_CH_EN = 8'h04;
    localparam logic [7:0] OFS_ACTION = 8'h08;
    localparam logic [7:0] OFS_PRE_LO = 8'h0C;
    localparam logic [7:0] OFS_PRE_HI = 8'h10;
    localparam logic [7:0] OFS_FLAG_OP = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_CTRL = 8'h20;
    // field positions
    localparam int POS_CNT_A = 0;
    localparam int POS_CNT_B = 16;
    localparam int POS_ST_FLAG = 4;
    localparam int POS_ST_SAT = 16;
    localparam int POS_CTRL_RESTART = 0;
    // reset values
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [11:0] RST_CH_EN = 12'h000;
    localparam logic [23:0] RST_ACTION = 24'h000000;
    localparam logic [31:0] RST_PRE_LO = 32'h00000000;
    localparam logic [15:0] RST_PRE_HI = 16'h0000;
    localparam logic [23:0] RST_FLAG_OP = 24'h000000;
    localparam logic [31:0] RST_COUNT = 32'h00000000;
    // channel indices (zero based): two that carry a count condition, one that only breaks
    localparam int CNT_CH_A = 1;
    localparam int CNT_CH_B = 10;
    localparam int BRK_ONLY_CH = 6;
    // channel capability masks, bit n is channel n+1
    localparam logic [11:0] TRACE_OK = 12'h9B0;
    localparam logic [11:0] CPU_GROUP = 12'hE7F;
    localparam logic [11:0] BUS_GROUP = 12'h180;
    // prerequisite selector codes
    localparam logic [3:0] PRE_NONE = 4'h0;
    localparam logic [3:0] PRE_FLAG = 4'hF;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MODE_OFF = 4'h0, MODE_P2_1 = 4'h1, MODE_P4_3 = 4'h2, MODE_P6_5 = 4'h3,
        MODE_P11_10 = 4'h4, MODE_C3 = 4'h5, MODE_C4 = 4'h6, MODE_C5 = 4'h7,
        MODE_C6 = 4'h8, MODE_C7 = 4'h9, MODE_C8 = 4'hA, MODE_B9_8 = 4'hB,
        MODE_B8_9 = 4'hC, MODE_CPU_FREE = 4'hD, MODE_BUS_FREE = 4'hE
    } ssq_mode_t;

    typedef enum logic [1:0] {
        ACT_BREAK = 2'h0, ACT_TRACE = 2'h1, ACT_PERF_START = 2'h2, ACT_PERF_END = 2'h3
    } ssq_act_t;

    typedef enum logic [1:0] {
        FOP_NONE = 2'h0, FOP_SET = 2'h1, FOP_CLEAR = 2'h2
    } ssq_fop_t;
endpackage

/* design/ssq_sequencer.sv */
// sequential break sequencer: chains channel matches and requests a halt
// assumes channel comparators give one-cycle match pulses synchronous to CLK
`timescale 1ns/1ps

module ssq_sequencer (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [11:0] CH_MATCH,
    input wire logic CORE_HALTED,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [31:0] ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic BREAK_REQ,
    output logic TRACE_REQ,
    output logic PERF_START,
    output logic PERF_END,
    output logic MATCH_FLAG
);
    import ssq_pkg::*;

    logic [3:0] mode_reg;
    logic [11:0] ch_en_reg;
    logic [23:0] action_reg;
    logic [31:0] pre_lo_reg;
    logic [15:0] pre_hi_reg;
    logic [23:0] flag_op_reg;
    logic [31:0] count_reg;
    logic [15:0] cnt_a_reg, cnt_b_reg;
    logic [3:0] step_reg;
    logic [11:0] sat_reg, sat_next;
    logic [11:0] ev, qual, used_as_pre;
    logic hit_a, hit_b, flag_next, step_adv, restart, do_write;
    logic brk_next, trc_next, pst_next, pen_next;
    logic aw_held_reg, w_held_reg;
    logic [7:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic [7:0] wa;

    // channel number (1 based) at a given step of a fixed chain
    function automatic logic [3:0] seq_ch(input logic [3:0] m, input logic [3:0] s);
        logic [3:0] full [8];
        full = '{4'hB, 4'hA, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};
        unique case (m)
            MODE_P2_1: seq_ch = (s == 4'h0) ? 4'h2 : 4'h1;
            MODE_P4_3: seq_ch = (s == 4'h0) ? 4'h4 : 4'h3;
            MODE_P6_5: seq_ch = (s == 4'h0) ? 4'h6 : 4'h5;
            MODE_P11_10: seq_ch = (s == 4'h0) ? 4'hB : 4'hA;
            MODE_B9_8: seq_ch = (s == 4'h0) ? 4'h9 : 4'h8;
            MODE_B8_9: seq_ch = (s == 4'h0) ? 4'h8 : 4'h9;
            MODE_C3, MODE_C4, MODE_C5, MODE_C6, MODE_C7, MODE_C8: begin
                // each many-channel chain is a tail of the eight-step chain
                seq_ch = full[3'((4'h8 - seq_len(m)) + s)];
            end
            default: seq_ch = 4'h0;
        endcase
    endfunction

    // number of steps in a fixed chain, zero when the mode is not one
    function automatic logic [3:0] seq_len(input logic [3:0] m);
        unique case (m)
            MODE_P2_1, MODE_P4_3, MODE_P6_5, MODE_P11_10, MODE_B9_8, MODE_B8_9: seq_len = 4'h2;
            MODE_C3: seq_len = 4'h3;
            MODE_C4: seq_len = 4'h4;
            MODE_C5: seq_len = 4'h5;
            MODE_C6: seq_len = 4'h6;
            MODE_C7: seq_len = 4'h7;
            MODE_C8: seq_len = 4'h8;
            default: seq_len = 4'h0;
        endcase
    endfunction

    // prerequisite selector of channel i (0 based)
    function automatic logic [3:0] pre_of(input int i, input logic [31:0] lo,
                                           input logic [15:0] hi);
        logic [47:0] all;
        all = {hi, lo};
        pre_of = all[i*4 +: 4];
    endfunction

    // counted match: fires when the running count reaches the target
    function automatic logic count_hit(input logic [15:0] cnt, input logic [15:0] tgt);
        count_hit = (17'(cnt) + 17'h00001) >= ((tgt == 16'h0000) ? 17'h00001 : 17'(tgt));
    endfunction
    assign restart = BREAK_REQ | CORE_HALTED;
    // counted channels pass only every n-th raw match
    assign hit_a = CH_MATCH[CNT_CH_A] & ch_en_reg[CNT_CH_A]
                   & count_hit(cnt_a_reg, count_reg[POS_CNT_A +: 16]);
    assign hit_b = CH_MATCH[CNT_CH_B] & ch_en_reg[CNT_CH_B]
                   & count_hit(cnt_b_reg, count_reg[POS_CNT_B +: 16]);

    // match counters for the two counted channels
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_a_reg <= 16'h0000;
            cnt_b_reg <= 16'h0000;
        end else if (do_write && wa == OFS_COUNT) begin
            cnt_a_reg <= 16'h0000;
            cnt_b_reg <= 16'h0000;
        end else begin
            if (CH_MATCH[CNT_CH_A] && ch_en_reg[CNT_CH_A]) begin
                cnt_a_reg <= hit_a ? 16'h0000 : cnt_a_reg + 16'h0001;
            end
            if (CH_MATCH[CNT_CH_B] && ch_en_reg[CNT_CH_B]) begin
                cnt_b_reg <= hit_b ? 16'h0000 : cnt_b_reg + 16'h0001;
            end
        end
    end

    // bus channels 8 and 9 take their comparator match like any other
    always_comb begin
        ev = CH_MATCH & ch_en_reg;
        ev[CNT_CH_A] = hit_a;
        ev[CNT_CH_B] = hit_b;
    end

    // qualification and flag updates for channels of the active free-mode group, actions for every channel
    always_comb begin
        logic [11:0] grp;
        logic [3:0] p;
        logic [1:0] act;
        logic [1:0] fop;
        // cpu channels chain freely; bus channels chain freely
        grp = (mode_reg == MODE_CPU_FREE) ? CPU_GROUP
              : (mode_reg == MODE_BUS_FREE) ? BUS_GROUP : 12'h000;
        p = PRE_NONE;
        act = ACT_BREAK;
        fop = FOP_NONE;
        qual = ev;
        used_as_pre = 12'h000;
        sat_next = sat_reg;
        flag_next = MATCH_FLAG;
        brk_next = 1'b0;
        trc_next = 1'b0;
        pst_next = 1'b0;
        pen_next = 1'b0;
        step_adv = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            p = pre_of(i, pre_lo_reg, pre_hi_reg);
            if (grp[i] && p != PRE_NONE && p != PRE_FLAG && p <= 4'hC) begin
                used_as_pre[p - 4'h1] = 1'b1;
            end
        end
        for (int i = 0; i < NCH; i++) begin
            p = pre_of(i, pre_lo_reg, pre_hi_reg);
            act = (i == BRK_ONLY_CH) ? ACT_BREAK : action_reg[i*2 +: 2]; // channel 7 breaks
            fop = flag_op_reg[i*2 +: 2];
            if (grp[i]) begin
                // named prerequisite must be satisfied already
                if (p != PRE_NONE && p != PRE_FLAG) begin
                    qual[i] = ev[i] & (p <= 4'hC) & sat_reg[p - 4'h1];
                // flag prerequisite needs the flag set
                end else if (p == PRE_FLAG) begin
                    qual[i] = ev[i] & MATCH_FLAG;
                end
                if (qual[i]) begin
                    sat_next[i] = 1'b1;
                    // qualified match sets or clears the flag
                    if (fop == FOP_SET) begin
                        flag_next = 1'b1;
                    end else if (fop == FOP_CLEAR) begin
                        flag_next = 1'b0;
                    end
                end
            end
            // channel action; trace only where supported
            if (qual[i]) begin
                unique case (act)
                    ACT_BREAK: begin
                        // a prerequisite-only channel never breaks itself
                        if (seq_len(mode_reg) == 4'h0 && !(grp[i] && used_as_pre[i])) begin
                            brk_next = 1'b1;
                        end
                    end
                    ACT_TRACE: trc_next = trc_next | TRACE_OK[i];
                    ACT_PERF_START: pst_next = 1'b1;
                    ACT_PERF_END: pen_next = 1'b1;
                endcase
            end
        end
        if (seq_len(mode_reg) != 4'h0) begin
            if (ev[seq_ch(mode_reg, step_reg) - 4'h1]) begin
                if (step_reg == seq_len(mode_reg) - 4'h1) begin
                    brk_next = 1'b1;
                end else begin
                    step_adv = 1'b1;
                end
            end
        end
    end

    // progress through a fixed chain, cleared on break or mode change
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            step_reg <= 4'h0;
        end else if (restart || brk_next || (do_write && wa == OFS_MODE)
                     || (do_write && wa == OFS_CTRL && wdata_reg[POS_CTRL_RESTART])) begin
            step_reg <= 4'h0;
        end else if (step_adv) begin
            step_reg <= step_reg + 4'h1;
        end
    end

    // satisfied channels of the free modes, cleared the same way
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sat_reg <= 12'h000;
        end else if (restart || (do_write && wa == OFS_MODE)
                     || (do_write && wa == OFS_CTRL && wdata_reg[POS_CTRL_RESTART])) begin
            sat_reg <= 12'h000;
        end else begin
            sat_reg <= sat_next;
        end
    end

    // shared match flag returns to clear whenever the program halts
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MATCH_FLAG <= 1'b0;
        end else if (restart || (do_write && wa == OFS_MODE)) begin
            MATCH_FLAG <= 1'b0;
        end else begin
            MATCH_FLAG <= flag_next;
        end
    end

    // one-cycle request pulses towards the core and trace/perf units
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BREAK_REQ <= 1'b0;
            TRACE_REQ <= 1'b0;
            PERF_START <= 1'b0;
            PERF_END <= 1'b0;
        end else begin
            BREAK_REQ <= brk_next & ~BREAK_REQ;
            TRACE_REQ <= trc_next;
            PERF_START <= pst_next;
            PERF_END <= pen_next;
        end
    end

    // write address and data are captured independently, in either order
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end else begin
            if (AWVALID && AWREADY) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= AWADDR[7:0];
            end
            if (WVALID && WREADY) begin
                w_held_reg <= 1'b1;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end
        end
    end

    assign do_write = aw_held_reg & w_held_reg & ~BVALID;
    assign wa = {awaddr_reg[7:2], 2'b00};

    // ready flags and write response
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else begin
            AWREADY <= ~aw_held_reg & ~(AWVALID & AWREADY) & ~BVALID & ~do_write;
            WREADY <= ~w_held_reg & ~(WVALID & WREADY) & ~BVALID & ~do_write;
            if (do_write) begin
                BVALID <= 1'b1;
                BRESP <= (wa <= OFS_CTRL && wa != OFS_STATUS) ? RESP_OKAY : RESP_SLVERR;
            end else if (BVALID && BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // configuration registers, byte lanes honoured
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_reg <= RST_MODE;
            ch_en_reg <= RST_CH_EN;
            action_reg <= RST_ACTION;
            pre_lo_reg <= RST_PRE_LO;
            pre_hi_reg <= RST_PRE_HI;
            flag_op_reg <= RST_FLAG_OP;
            count_reg <= RST_COUNT;
        end else if (do_write) begin
            for (int b = 0; b < 4; b++) begin
                if (wstrb_reg[b]) begin
                    unique case (wa)
                        OFS_MODE: if (b == 0) mode_reg <= wdata_reg[3:0];
                        OFS_CH_EN: if (b < 2) ch_en_reg[b*8 +: 4] <= wdata_reg[b*8 +: 4];
                        OFS_ACTION: if (b < 3) action_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        OFS_PRE_LO: pre_lo_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        OFS_PRE_HI: if (b < 2) pre_hi_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        OFS_FLAG_OP: if (b < 3) flag_op_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        OFS_COUNT: count_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
                        default: ;
                    endcase
                end
            end
            if (wstrb_reg[0] && wa == OFS_CH_EN) begin
                ch_en_reg[7:4] <= wdata_reg[7:4];
            end
        end
    end

    // read channel: one read at a time, answer the cycle after the address
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h00000000;
            RRESP <= RESP_OKAY;
        end else begin
            ARREADY <= ~RVALID & ~(ARVALID & ARREADY);
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP <= RESP_OKAY;
                unique case ({ARADDR[7:2], 2'b00})
                    OFS_MODE: RDATA <= {28'h0000000, mode_reg};
                    OFS_CH_EN: RDATA <= {20'h00000, ch_en_reg};
                    OFS_ACTION: RDATA <= {8'h00, action_reg};
                    OFS_PRE_LO: RDATA <= pre_lo_reg;
                    OFS_PRE_HI: RDATA <= {16'h0000, pre_hi_reg};
                    OFS_FLAG_OP: RDATA <= {8'h00, flag_op_reg};
                    OFS_COUNT: RDATA <= count_reg;
                    OFS_STATUS: RDATA <= {4'h0, sat_reg, 11'h000, MATCH_FLAG, step_reg};
                    OFS_CTRL: RDATA <= 32'h00000000;
                    default: begin
                        RDATA <= 32'h00000000;
                        RRESP <= RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end
endmodule

/* verification/ssq_core_model.sv */
// partner: stands in for the monitored core and bus comparators
// assumes the bench asks for one event or halt cycle at a time
`timescale 1ns/1ps
module ssq_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] ev,
    input wire logic halt_ev,
    output logic [11:0] ch_match,
    output logic core_halted
);
    // comparator hits leave as single-cycle pulses on the core clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch_match <= 12'h000;
        end else begin
            ch_match <= ev;
        end
    end

    // halts from other causes, also single-cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            core_halted <= 1'b0;
        end else begin
            core_halted <= halt_ev;
        end
    end
endmodule

/* verification/ssq_sequencer_chk.sv */
// checker: timing and cause relations on the sequencer outputs
// assumes it is bound to ssq_sequencer and sees only its ports
`timescale 1ns/1ps
module ssq_sequencer_chk (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [11:0] CH_MATCH,
    input wire logic CORE_HALTED,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic BREAK_REQ,
    input wire logic TRACE_REQ,
    input wire logic PERF_START,
    input wire logic PERF_END,
    input wire logic MATCH_FLAG
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    a_break_pulse: assert property (BREAK_REQ |=> !BREAK_REQ)
        else $error("break request longer than one cycle");
    a_break_cause: assert property (BREAK_REQ |-> $past(CH_MATCH) != 12'h000)
        else $error("break request without a preceding match");
    a_flag_break: assert property ((BREAK_REQ && CH_MATCH == 12'h000) |=> !MATCH_FLAG)
        else $error("flag survived a break");
    a_flag_halt: assert property ((CORE_HALTED && CH_MATCH == 12'h000) |=> !MATCH_FLAG)
        else $error("flag survived a core halt");
    a_flag_set: assert property ($rose(MATCH_FLAG) |-> $past(CH_MATCH) != 12'h000)
        else $error("flag set without a match");
    a_trace_cause: assert property (TRACE_REQ |-> $past(CH_MATCH) != 12'h000)
        else $error("trace pulse without a match");
    a_perf_cause: assert property ((PERF_START || PERF_END) |-> $past(CH_MATCH) != 12'h000)
        else $error("perf mark without a match");
    a_bresp_hold: assert property ((BVALID && !BREADY) |=> BVALID && $stable(BRESP))
        else $error("write response dropped early");
    a_rdata_hold: assert property ((RVALID && !RREADY) |=> RVALID && $stable(RDATA))
        else $error("read data dropped early");
    a_write_answer: assert property ((AWVALID && AWREADY && WVALID && WREADY) |-> ##[1:3] BVALID)
        else $error("write response late");

    c_break: cover property (BREAK_REQ);
    c_trace: cover property (TRACE_REQ);
    c_flag: cover property ($rose(MATCH_FLAG));
endmodule

bind ssq_sequencer ssq_sequencer_chk ssq_sequencer_chk_inst (
    .CLK(CLK), .RST_N(RST_N), .CH_MATCH(CH_MATCH), .CORE_HALTED(CORE_HALTED),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .BREAK_REQ(BREAK_REQ), .TRACE_REQ(TRACE_REQ), .PERF_START(PERF_START),
    .PERF_END(PERF_END), .MATCH_FLAG(MATCH_FLAG)
);

/* verification/sequential_break_sequencer_tb.sv */
// testbench: register bus tasks, chained match stimulus and output counting
// assumes the core model partner and the bound checker
`timescale 1ns/1ps
module sequential_break_sequencer_tb;
    import ssq_pkg::*;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, halt_ev, core_halted;
    logic awready, wready, bvalid, arready, rvalid;
    logic break_req, trace_req, perf_start, perf_end, match_flag;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [11:0] ev, ch_match;
    logic [1:0] bresp, rresp;
    int fail_count = 0;
    int checks = 0;
    int act_cnt[4] = '{0, 0, 0, 0};
    int base[4];
    int i, k;
    logic [31:0] seq_tab[12] = '{32'h21, 32'h43, 32'h65, 32'hBA, 32'h321, 32'h4321, 32'h54321,
        32'h654321, 32'hA654321, 32'hBA654321, 32'h98, 32'h89};
    int len_tab[12] = '{2, 2, 2, 2, 3, 4, 5, 6, 7, 8, 2, 2};

    ssq_sequencer ssq_sequencer_inst (
        .CLK(clk), .RST_N(rst_n), .CH_MATCH(ch_match), .CORE_HALTED(core_halted),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(3'h0),
        .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'hF),
        .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(3'h0),
        .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
        .BREAK_REQ(break_req), .TRACE_REQ(trace_req), .PERF_START(perf_start),
        .PERF_END(perf_end), .MATCH_FLAG(match_flag)
    );
    ssq_core_model ssq_core_model_inst (.clk(clk), .rst_n(rst_n), .ev(ev), .halt_ev(halt_ev),
        .ch_match(ch_match), .core_halted(core_halted));

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // count every output pulse
    always @(posedge clk) begin
        act_cnt[0] += int'(break_req === 1'b1);
        act_cnt[1] += int'(trace_req === 1'b1);
        act_cnt[2] += int'(perf_start === 1'b1);
        act_cnt[3] += int'(perf_end === 1'b1);
    end

    task final_report;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task cmp_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task cmp_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        @(posedge clk);
        awvalid <= 1'b1;
        awaddr <= {24'h0, a};
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        cmp_word({30'h0, bresp}, {30'h0, er}, "write response");
        bready <= 1'b0;
    endtask

    task axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= {24'h0, a};
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        cmp_word({30'h0, rresp}, {30'h0, er}, "read response");
        rready <= 1'b0;
    endtask

    // one comparator hit on channel ch, then time to settle
    task pulse(input int ch);
        @(posedge clk);
        ev <= 12'h001 << (ch - 1);
        @(posedge clk);
        ev <= 12'h000;
        repeat (4) @(posedge clk);
    endtask

    task set_mode(input logic [3:0] m);
        axi_wr(OFS_MODE, {28'h0, m}, RESP_OKAY);
        base = act_cnt;
    endtask

    task exp_brk(input int n);
        cmp_word(32'(act_cnt[0] - base[0]), 32'(n), "break count");
    endtask

    // fixed chain: stray last, partial then mode rewrite, then the full order
    task run_chain(input logic [3:0] m, input logic [31:0] s, input int n);
        int j;
        set_mode(m);
        pulse(int'(s[3:0]));
        for (j = n - 1; j > 0; j--) pulse(int'(s[j*4+:4]));
        exp_brk(0);
        set_mode(m);
        pulse(int'(s[3:0]));
        exp_brk(0);
        for (j = n - 1; j >= 0; j--) pulse(int'(s[j*4+:4]));
        exp_brk(1);
        axi_rd(OFS_STATUS, rd, RESP_OKAY);
        cmp_word({28'h0, rd[3:0]}, 32'h0, "chain step");
    endtask

    // watchdog
    initial begin
        #300000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        rst_n = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
        awaddr = 0; wdata = 0; araddr = 0; ev = 0; halt_ev = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // reset values, widths and unmapped places
        for (i = 0; i < 8; i++) begin
            axi_rd(8'(i * 4), rd, RESP_OKAY);
            cmp_word(rd, 32'h0, "reset value");
        end
        axi_wr(OFS_CH_EN, 32'hFFFFFFFF, RESP_OKAY);
        axi_rd(OFS_CH_EN, rd, RESP_OKAY);
        cmp_word(rd, 32'h00000FFF, "enable width");
        axi_wr(8'h24, 32'h1, RESP_SLVERR);
        axi_wr(OFS_STATUS, 32'h1, RESP_SLVERR);
        axi_rd(8'h24, rd, RESP_SLVERR);
        cmp_word(rd, 32'h0, "unmapped read");
        // every fixed chain mode
        for (i = 0; i < 12; i++) run_chain(4'(i + 1), seq_tab[i], len_tab[i]);
        // restart in mid-chain drops progress
        base = act_cnt;
        pulse(8);
        axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
        pulse(9);
        exp_brk(0);
        // counted channels, and a disabled one
        set_mode(MODE_OFF);
        axi_wr(OFS_CH_EN, 32'h402, RESP_OKAY);
        axi_wr(OFS_COUNT, 32'h00020003, RESP_OKAY);
        pulse(1);
        pulse(2);
        pulse(2);
        exp_brk(0);
        pulse(2);
        exp_brk(1);
        pulse(11);
        pulse(11);
        exp_brk(2);
        // every action code on a trace-capable channel
        axi_wr(OFS_CH_EN, 32'h010, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            axi_wr(OFS_ACTION, 32'(i) << 8, RESP_OKAY);
            base = act_cnt;
            pulse(5);
            for (k = 0; k < 4; k++) cmp_word(32'(act_cnt[k] - base[k]), 32'(k == i), "act");
        end
        // free cpu chain 2,1,4,10 plus flag users 3 (set), 12 (clear), 5 (needs flag)
        axi_wr(OFS_COUNT, 32'h0, RESP_OKAY);
        axi_wr(OFS_ACTION, 32'h00C00020, RESP_OKAY);
        axi_wr(OFS_FLAG_OP, 32'h00800010, RESP_OKAY);
        axi_wr(OFS_PRE_LO, 32'h000F1002, RESP_OKAY);
        axi_wr(OFS_PRE_HI, 32'h40, RESP_OKAY);
        axi_wr(OFS_CH_EN, 32'hA1F, RESP_OKAY);
        set_mode(MODE_CPU_FREE);
        pulse(1);
        pulse(2);
        pulse(1);
        pulse(4);
        exp_brk(0);
        pulse(10);
        exp_brk(1);
        pulse(5);
        exp_brk(1);
        pulse(3);
        cmp_bit(match_flag, 1'b1, "flag set");
        pulse(5);
        exp_brk(2);
        cmp_bit(match_flag, 1'b0, "flag after break");
        pulse(3);
        pulse(12);
        cmp_bit(match_flag, 1'b0, "flag cleared");
        pulse(3);
        @(posedge clk);
        halt_ev <= 1'b1;
        @(posedge clk);
        halt_ev <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_bit(match_flag, 1'b0, "flag after halt");
        // free bus chain 8 then 9
        axi_wr(OFS_PRE_LO, 32'h0, RESP_OKAY);
        axi_wr(OFS_PRE_HI, 32'h8, RESP_OKAY);
        axi_wr(OFS_ACTION, 32'h0, RESP_OKAY);
        axi_wr(OFS_CH_EN, 32'h180, RESP_OKAY);
        set_mode(MODE_BUS_FREE);
        pulse(9);
        pulse(8);
        exp_brk(0);
        pulse(9);
        exp_brk(1);
        final_report;
    end
endmodule
